// file: rtl/console_pkg.sv
`default_nettype none
package console_pkg;

  localparam int DATA_W = 18;
  localparam int ADDR_W = 15;
  localparam int NUM_SEL = 12;
  localparam int SEL_W = 4;

  // Switch indices in the momentary switch vector
  localparam int SW_START = 0;
  localparam int SW_RESUME = 1;
  localparam int SW_ST_THIS = 2;
  localparam int SW_ST_NEXT = 3;
  localparam int SW_LD_THIS = 4;
  localparam int SW_LD_NEXT = 5;
  localparam int SW_STOP = 6;
  localparam int SW_RUN_SINGLE_SWITCH_INSTRUCTION = 7;
  localparam int SW_RESET = 8;
  localparam int SW_TAPE_BOOTSTRAP_LOAD = 9;
  localparam int NUM_SW = 10;

  // Stepping mode switch codes
  localparam logic [1:0] STEP_NONE = 2'h0;
  localparam logic [1:0] STEP_PHASE = 2'h1;
  localparam logic [1:0] STEP_MAJOR = 2'h2;
  localparam logic [1:0] STEP_OPCODE = 2'h3;

  // Debounce timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int DEBOUNCE_NS = 1000;
  localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DB_W = 16;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_MBUF = 8'h08;
  localparam logic [7:0] OFF_LAMPS = 8'h0C;
  localparam logic [7:0] OFF_COUNTS = 8'h10;

  // Field positions and reset values
  localparam int CTRL_LOCK_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_STOP_BIT = 1;
  localparam int STAT_TAPE_BIT = 2;
  localparam int STAT_STATE_LSB = 4;
  localparam int CNT_LOAD_LSB = 16;

  typedef enum logic [2:0] {
    ST_HALT,
    ST_RUN,
    ST_STEP,
    ST_MEM,
    ST_TAPE
  } state_t;

  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mem_cmd_t;

endpackage
`default_nettype wire

// file: rtl/operator_console_control.sv
// Behaviour
// RQ1: Start loads address switches as next instruction address and runs.
// RQ2: Resume without stepping mode continues from the held program counter.
// RQ3: Resume with stepping mode advances one time state, major state or instruction.
// RQ4: Store-this writes data switches to the word at the address switches.
// RQ5: Store-next writes to address switches plus count of store-next presses.
// RQ6: Load-this reads word at address switches into the memory buffer.
// RQ7: Load-next reads address switches plus count of load-next presses into buffer.
// RQ8: Console store and load leave processor registers unchanged.
// RQ9: Stop lets the current instruction finish, then halts.
// RQ10: Stop never blocks data channel transfers.
// RQ11: Execute runs the data switch word as one instruction, then halts.
// RQ12: Reset clears major registers, flags and option selects.
// RQ13: Tape bootstrap starts hardware transfer of tape words into memory.
// RQ14: Tape words go to address switches, then successive locations.
// RQ15: While running, every action switch except stop is ignored.
// RQ16: Reset with stop while running forces an unconditional reset.
// RQ17: Front bank position shows the left-list register on the lamps.
// RQ18: Rear bank position shows the right-list maintenance item on the lamps.
// RQ19: Twelve select positions with bank selector choose the lamp source.
// RQ20: Data switches supply one 18-bit word.
// RQ21: Address switches hold fifteen bits.
// RQ22: Each press is synchronised and debounced into one one-cycle pulse.
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
module operator_console_control #(
  parameter int DEBOUNCE_CYCLES = console_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [console_pkg::NUM_SW-1:0] switch_press,
  input wire logic [1:0] step_mode,
  input wire logic [console_pkg::DATA_W-1:0] data_switches,
  input wire logic [console_pkg::ADDR_W-1:0] address_switches,
  input wire logic display_bank_selector,
  input wire logic [console_pkg::SEL_W-1:0] register_select,
  input wire logic [console_pkg::NUM_SEL-1:0][console_pkg::DATA_W-1:0] left_sources,
  input wire logic [console_pkg::NUM_SEL-1:0][console_pkg::DATA_W-1:0] right_sources,
  output logic [console_pkg::DATA_W-1:0] lamps,
  output logic [console_pkg::DATA_W-1:0] memory_buffer,
  output logic core_run,
  output logic core_start_req,
  output logic [console_pkg::ADDR_W-1:0] core_start_addr,
  output logic core_step_req,
  output logic [1:0] core_step_kind,
  output logic core_run_single_switch_instruction_req,
  output logic [console_pkg::DATA_W-1:0] core_run_single_switch_instruction_word,
  output logic core_clear,
  input wire logic core_instr_done,
  input wire logic core_step_done,
  output logic mem_req,
  output console_pkg::mem_cmd_t mem_cmd,
  input wire logic mem_ack,
  input wire logic [console_pkg::DATA_W-1:0] mem_rdata,
  output logic tape_ready,
  input wire logic tape_valid,
  input wire logic [console_pkg::DATA_W-1:0] tape_word,
  input wire logic tape_end
);

  function automatic logic [console_pkg::ADDR_W-1:0] addr_plus(
    input logic [console_pkg::ADDR_W-1:0] base,
    input logic [console_pkg::ADDR_W-1:0] offs
  );
    addr_plus = base + offs;
  endfunction

  // Switch conditioning
  logic [console_pkg::NUM_SW-1:0] sync1_reg;
  logic [console_pkg::NUM_SW-1:0] sync2_reg;
  logic [console_pkg::NUM_SW-1:0] stable_reg;
  logic [console_pkg::NUM_SW-1:0] press_reg;
  logic [console_pkg::DB_W-1:0] db_cnt_reg [console_pkg::NUM_SW];

  always_ff @(posedge clk) begin
    sync1_reg <= switch_press;
    sync2_reg <= sync1_reg;
    for (int i = 0; i < console_pkg::NUM_SW; i++) begin
      if (!rst_n) begin
        stable_reg[i] <= 1'b0;
        press_reg[i] <= 1'b0;
        db_cnt_reg[i] <= '0;
      end else if (sync2_reg[i] != stable_reg[i]) begin
        // A level must hold for the full window, so contact bounce never doubles a press
        if (db_cnt_reg[i] == console_pkg::DB_W'(DEBOUNCE_CYCLES - 1)) begin
          stable_reg[i] <= sync2_reg[i];
          press_reg[i] <= sync2_reg[i]; // see RQ22
          db_cnt_reg[i] <= '0;
        end else begin
          press_reg[i] <= 1'b0;
          db_cnt_reg[i] <= db_cnt_reg[i] + 1'b1;
        end
      end else begin
        press_reg[i] <= 1'b0;
        db_cnt_reg[i] <= '0;
      end
    end
  end

  // State
  console_pkg::state_t state_reg;
  logic ctrl_lock_reg;
  logic stop_pend_reg;
  logic tape_active_reg;
  logic [console_pkg::ADDR_W-1:0] store_cnt_reg;
  logic [console_pkg::ADDR_W-1:0] load_cnt_reg;
  logic [console_pkg::ADDR_W-1:0] tape_cnt_reg;

  wire halted = (state_reg == console_pkg::ST_HALT);
  wire [console_pkg::NUM_SW-1:0] act = press_reg & {console_pkg::NUM_SW{~ctrl_lock_reg}};
  wire [console_pkg::NUM_SW-1:0] held = press_reg | stable_reg;
  wire do_start = halted & act[console_pkg::SW_START]; // see RQ15
  wire do_resume = halted & act[console_pkg::SW_RESUME];
  wire do_st_this = halted & act[console_pkg::SW_ST_THIS];
  wire do_st_next = halted & act[console_pkg::SW_ST_NEXT];
  wire do_ld_this = halted & act[console_pkg::SW_LD_THIS];
  wire do_ld_next = halted & act[console_pkg::SW_LD_NEXT];
  wire do_run_single_switch_instruction = halted & act[console_pkg::SW_RUN_SINGLE_SWITCH_INSTRUCTION];
  wire do_tape_bootstrap_load = halted & act[console_pkg::SW_TAPE_BOOTSTRAP_LOAD];
  wire do_reset = halted & act[console_pkg::SW_RESET];
  wire do_stop = ~halted & act[console_pkg::SW_STOP];
  wire force_reset = ~halted & ~ctrl_lock_reg & held[console_pkg::SW_RESET] & held[console_pkg::SW_STOP]
                     & (press_reg[console_pkg::SW_RESET] | press_reg[console_pkg::SW_STOP]); // see RQ16
  wire any_clear = do_reset | force_reset;
  wire tape_take = (state_reg == console_pkg::ST_TAPE) & tape_valid & ~tape_end;
  wire [console_pkg::ADDR_W-1:0] st_next_addr = addr_plus(address_switches, store_cnt_reg); // see RQ5
  wire [console_pkg::ADDR_W-1:0] ld_next_addr = addr_plus(address_switches, load_cnt_reg); // see RQ7
  wire [console_pkg::ADDR_W-1:0] tape_addr = addr_plus(address_switches, tape_cnt_reg); // see RQ14

  assign tape_ready = (state_reg == console_pkg::ST_TAPE) & ~force_reset;
  assign core_run = (state_reg == console_pkg::ST_RUN);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= console_pkg::ST_HALT;
      stop_pend_reg <= 1'b0;
      tape_active_reg <= 1'b0;
      store_cnt_reg <= '0;
      load_cnt_reg <= '0;
      tape_cnt_reg <= '0;
      memory_buffer <= '0;
      core_start_req <= 1'b0;
      core_start_addr <= '0;
      core_step_req <= 1'b0;
      core_step_kind <= console_pkg::STEP_NONE;
      core_run_single_switch_instruction_req <= 1'b0;
      core_run_single_switch_instruction_word <= '0;
      core_clear <= 1'b0;
      mem_req <= 1'b0;
      mem_cmd <= '0;
    end else begin
      core_start_req <= 1'b0;
      core_step_req <= 1'b0;
      core_run_single_switch_instruction_req <= 1'b0;
      core_clear <= 1'b0;
      if (any_clear) begin
        // Core registers are cleared by the pulse; a forced reset abandons any memory cycle
        core_clear <= 1'b1; // see RQ12
        memory_buffer <= '0;
        store_cnt_reg <= '0;
        load_cnt_reg <= '0;
        stop_pend_reg <= 1'b0;
        tape_active_reg <= 1'b0;
        mem_req <= 1'b0;
        state_reg <= console_pkg::ST_HALT;
      end else begin
        case (state_reg)
          console_pkg::ST_HALT: begin
            if (do_start) begin
              core_start_req <= 1'b1; // see RQ1
              core_start_addr <= address_switches; // see RQ21
              state_reg <= console_pkg::ST_RUN;
            end else if (do_resume && step_mode == console_pkg::STEP_NONE) begin
              state_reg <= console_pkg::ST_RUN; // see RQ2
            end else if (do_resume) begin
              core_step_req <= 1'b1; // see RQ3
              core_step_kind <= step_mode;
              state_reg <= console_pkg::ST_STEP;
            end else if (do_run_single_switch_instruction) begin
              core_run_single_switch_instruction_req <= 1'b1; // see RQ11
              core_run_single_switch_instruction_word <= data_switches; // see RQ20
              state_reg <= console_pkg::ST_STEP;
            end else if (do_st_this || do_st_next) begin
              // Memory port only; no core register is touched
              mem_req <= 1'b1; // see RQ4 RQ8
              mem_cmd <= '{we: 1'b1, addr: do_st_this ? address_switches : st_next_addr, wdata: data_switches};
              if (do_st_next) begin
                store_cnt_reg <= store_cnt_reg + 1'b1;
              end
              state_reg <= console_pkg::ST_MEM;
            end else if (do_ld_this || do_ld_next) begin
              mem_req <= 1'b1; // see RQ6 RQ8
              mem_cmd <= '{we: 1'b0, addr: do_ld_this ? address_switches : ld_next_addr, wdata: '0};
              if (do_ld_next) begin
                load_cnt_reg <= load_cnt_reg + 1'b1;
              end
              state_reg <= console_pkg::ST_MEM;
            end else if (do_tape_bootstrap_load) begin
              tape_active_reg <= 1'b1; // see RQ13
              tape_cnt_reg <= '0;
              state_reg <= console_pkg::ST_TAPE;
            end
          end
          console_pkg::ST_RUN: begin
            // Halting only drops run; data channel service lives in the core and goes on
            if (do_stop) begin
              stop_pend_reg <= 1'b1; // see RQ10
            end
            if (core_instr_done && (stop_pend_reg || do_stop)) begin
              stop_pend_reg <= 1'b0; // see RQ9
              state_reg <= console_pkg::ST_HALT;
            end
          end
          console_pkg::ST_STEP: begin
            if (core_step_done) begin
              state_reg <= console_pkg::ST_HALT; // see RQ3 RQ11
            end
          end
          console_pkg::ST_MEM: begin
            if (mem_ack) begin
              mem_req <= 1'b0;
              if (!mem_cmd.we) begin
                memory_buffer <= mem_rdata; // see RQ6 RQ7
              end
              state_reg <= tape_active_reg ? console_pkg::ST_TAPE : console_pkg::ST_HALT;
            end
          end
          console_pkg::ST_TAPE: begin
            if (tape_end || do_stop) begin
              tape_active_reg <= 1'b0;
              state_reg <= console_pkg::ST_HALT;
            end else if (tape_take) begin
              mem_req <= 1'b1; // see RQ13
              mem_cmd <= '{we: 1'b1, addr: tape_addr, wdata: tape_word}; // see RQ14
              tape_cnt_reg <= tape_cnt_reg + 1'b1;
              state_reg <= console_pkg::ST_MEM;
            end
          end
          default: begin
            state_reg <= console_pkg::ST_HALT;
          end
        endcase
      end
    end
  end

  // Lamp display
  wire sel_valid = (register_select < console_pkg::SEL_W'(console_pkg::NUM_SEL)); // see RQ19
  wire [console_pkg::DATA_W-1:0] left_pick = left_sources[register_select]; // see RQ17
  wire [console_pkg::DATA_W-1:0] right_pick = right_sources[register_select]; // see RQ18
  wire [console_pkg::DATA_W-1:0] lamp_next = !sel_valid ? '0 : (display_bank_selector ? right_pick : left_pick);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lamps <= '0;
    end else begin
      lamps <= lamp_next;
    end
  end

  // Bus slave: zero wait states, always OKAY
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  wire bus_take = hsel & htrans[1] & hready;
  wire [7:0] rd_addr = haddr[7:0];
  wire [31:0] status_word = {25'h0, 3'(state_reg), 1'b0, tape_active_reg, stop_pend_reg, core_run};
  wire [31:0] rd_mux = (rd_addr == console_pkg::OFF_CTRL) ? {31'h0, ctrl_lock_reg} :
                       (rd_addr == console_pkg::OFF_STATUS) ? status_word :
                       (rd_addr == console_pkg::OFF_MBUF) ? {14'h0, memory_buffer} :
                       (rd_addr == console_pkg::OFF_LAMPS) ? {14'h0, lamps} :
                       (rd_addr == console_pkg::OFF_COUNTS) ? {1'b0, load_cnt_reg, 1'b0, store_cnt_reg} :
                       32'h0000_0000;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      ctrl_lock_reg <= console_pkg::CTRL_RESET;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= bus_take & hwrite;
      wr_addr_reg <= rd_addr;
      if (bus_take && !hwrite) begin
        hrdata <= rd_mux;
      end
      if (wr_pend_reg && wr_addr_reg == console_pkg::OFF_CTRL) begin
        ctrl_lock_reg <= hwdata[console_pkg::CTRL_LOCK_BIT];
      end
    end
  end

  // Checks
  sequence s_mem_write(logic [console_pkg::ADDR_W-1:0] a);
    mem_req && mem_cmd.we && mem_cmd.addr == a;
  endsequence

  property p_start;
    @(posedge clk) disable iff (!rst_n)
    do_start && !any_clear |=> core_start_req && core_run && core_start_addr == $past(address_switches);
  endproperty
  a_start: assert property (p_start) else $error("start did not load address and run"); // see RQ1

  property p_resume;
    @(posedge clk) disable iff (!rst_n)
    do_resume && step_mode == console_pkg::STEP_NONE && !any_clear |=> core_run && !core_start_req;
  endproperty
  a_resume: assert property (p_resume) else $error("resume did not continue"); // see RQ2

  property p_step;
    @(posedge clk) disable iff (!rst_n)
    do_resume && step_mode != console_pkg::STEP_NONE && !any_clear
      |=> core_step_req && !core_run && core_step_kind == $past(step_mode);
  endproperty
  a_step: assert property (p_step) else $error("step request wrong"); // see RQ3

  logic [console_pkg::DATA_W-1:0] data_sw_q;
  assign data_sw_q = data_switches;

  property p_store;
    @(posedge clk) disable iff (!rst_n)
    do_st_this && !any_clear |=> s_mem_write($past(address_switches)) && mem_cmd.wdata == $past(data_sw_q);
  endproperty
  a_store: assert property (p_store) else $error("store wrong address or data"); // see RQ4

  property p_store_next;
    @(posedge clk) disable iff (!rst_n)
    do_st_next && !any_clear |=> s_mem_write($past(address_switches) + $past(store_cnt_reg))
      && store_cnt_reg == $past(store_cnt_reg) + 1'b1;
  endproperty
  a_store_next: assert property (p_store_next) else $error("store next address wrong"); // see RQ5

  property p_stop_wait;
    @(posedge clk) disable iff (!rst_n)
    core_run && !core_instr_done && !any_clear |=> core_run;
  endproperty
  a_stop_wait: assert property (p_stop_wait) else $error("halted mid instruction"); // see RQ9

  property p_ignore;
    @(posedge clk) disable iff (!rst_n)
    !halted && (act[console_pkg::SW_START] || act[console_pkg::SW_ST_THIS])
      |=> !core_start_req && !core_run_single_switch_instruction_req && !core_step_req && ($past(mem_req) || !mem_req);
  endproperty
  a_ignore: assert property (p_ignore) else $error("action taken while running"); // see RQ15

  property p_clear;
    @(posedge clk) disable iff (!rst_n)
    any_clear |=> core_clear && memory_buffer == '0 && halted && !mem_req;
  endproperty
  a_clear: assert property (p_clear) else $error("reset did not clear"); // see RQ12 RQ16

  property p_tape_first;
    @(posedge clk) disable iff (!rst_n)
    tape_take && tape_cnt_reg == '0 && !do_stop && !any_clear |=> s_mem_write($past(address_switches));
  endproperty
  a_tape_first: assert property (p_tape_first) else $error("first tape word misplaced"); // see RQ14

  property p_lamps;
    @(posedge clk) disable iff (!rst_n)
    sel_valid && display_bank_selector |=> lamps == $past(right_pick);
  endproperty
  a_lamps: assert property (p_lamps) else $error("rear bank lamps wrong"); // see RQ18

  property p_one_pulse;
    @(posedge clk) disable iff (!rst_n)
    press_reg[console_pkg::SW_ST_NEXT] |=> !press_reg[console_pkg::SW_ST_NEXT] [*3];
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("press gave more than one pulse"); // see RQ22

endmodule // operator_console_control
`default_nettype wire

// file: tb/core_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_mem_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic core_run,
  input wire logic core_step_req,
  input wire logic core_run_single_switch_instruction_req,
  output logic core_instr_done,
  output logic core_step_done,
  input wire logic mem_req,
  input wire console_pkg::mem_cmd_t mem_cmd,
  output logic mem_ack,
  output logic [17:0] mem_rdata,
  input wire logic tape_ready,
  output logic tape_valid,
  output logic [17:0] tape_word,
  output logic tape_end
);
  logic [17:0] mem [0:32767];
  logic [3:0] wait_cnt;
  logic [3:0] run_cnt;
  logic [2:0] step_dly;
  logic [1:0] n_words;
  initial begin
    {wait_cnt, run_cnt, step_dly, n_words} = '0;
    {core_instr_done, core_step_done, mem_ack, tape_valid, tape_end} = '0;
    mem_rdata = '0;
    tape_word = '0;
  end
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    // Read data only means something with the ack, so it toggles otherwise
    mem_rdata <= ~mem_rdata;
    if (mem_req && !mem_ack) begin
      wait_cnt <= wait_cnt + 4'h1;
      if (wait_cnt >= (slow ? 4'h6 : 4'h0)) begin
        mem_ack <= 1'b1;
        wait_cnt <= '0;
        if (mem_cmd.we) mem[mem_cmd.addr] <= mem_cmd.wdata;
        else mem_rdata <= mem[mem_cmd.addr];
      end
    end
    // Instructions end every sixteen cycles while running
    run_cnt <= core_run ? run_cnt + 4'h1 : 4'h0;
    core_instr_done <= core_run && run_cnt == 4'h7;
    step_dly <= {step_dly[1:0], core_step_req | core_run_single_switch_instruction_req};
    core_step_done <= step_dly[2];
    // Reader offers three words, then signals end of tape
    tape_valid <= 1'b0;
    tape_word <= ~tape_word;
    if (tape_ready && !tape_valid && !tape_end) begin
      if (n_words == 2'h3) begin
        tape_end <= 1'b1;
      end else begin
        tape_valid <= 1'b1;
        tape_word <= 18'h3_0000 | 18'(n_words);
        n_words <= n_words + 2'h1;
      end
    end else if (!tape_ready && tape_end) begin
      tape_end <= 1'b0;
      n_words <= '0;
    end
  end
endmodule // core_mem_model
`default_nettype wire

// file: tb/operator_console_control_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module operator_console_control_tb_top;
  localparam int DEB = 4;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, slow, bank, core_run, start_req, step_req, run_single_switch_instruction_req, clear_req;
  logic mem_req, mem_ack, tape_ready, tape_valid, tape_end, instr_done, step_done;
  logic [31:0] haddr, hwdata, hrdata, rdv;
  logic [1:0] htrans, step_mode, step_kind, last_kind;
  logic [2:0] hsize;
  logic [9:0] switch_press;
  logic [17:0] data_sw, lamps, mbuf, run_single_switch_instruction_word, mem_rdata, tape_word;
  logic [14:0] addr_sw, start_addr;
  logic [3:0] sel;
  logic [11:0][17:0] left_src, right_src;
  console_pkg::mem_cmd_t mem_cmd;
  int n_fail, n_tests, n_start, n_step, n_run_single_switch_instruction, n_clear, i, m;
  operator_console_control #(.DEBOUNCE_CYCLES(DEB)) dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .switch_press(switch_press), .step_mode(step_mode),
    .data_switches(data_sw), .address_switches(addr_sw), .display_bank_selector(bank), .register_select(sel),
    .left_sources(left_src), .right_sources(right_src), .lamps(lamps), .memory_buffer(mbuf),
    .core_run(core_run), .core_start_req(start_req), .core_start_addr(start_addr), .core_step_req(step_req),
    .core_step_kind(step_kind), .core_run_single_switch_instruction_req(run_single_switch_instruction_req), .core_run_single_switch_instruction_word(run_single_switch_instruction_word), .core_clear(clear_req),
    .core_instr_done(instr_done), .core_step_done(step_done), .mem_req(mem_req), .mem_cmd(mem_cmd),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .tape_ready(tape_ready), .tape_valid(tape_valid),
    .tape_word(tape_word), .tape_end(tape_end));
  core_mem_model u_model (.clk(clk), .slow(slow), .core_run(core_run), .core_step_req(step_req),
    .core_run_single_switch_instruction_req(run_single_switch_instruction_req), .core_instr_done(instr_done), .core_step_done(step_done), .mem_req(mem_req),
    .mem_cmd(mem_cmd), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .tape_ready(tape_ready),
    .tape_valid(tape_valid), .tape_word(tape_word), .tape_end(tape_end));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Pulses are counted here so each press can be tied to exactly one action
  always @(posedge clk) begin
    if (start_req === 1'b1) n_start <= n_start + 1;
    if (step_req === 1'b1) n_step <= n_step + 1;
    if (step_req === 1'b1) last_kind <= step_kind;
    if (run_single_switch_instruction_req === 1'b1) n_run_single_switch_instruction <= n_run_single_switch_instruction + 1;
    if (clear_req === 1'b1) n_clear <= n_clear + 1;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_ready;
    int k;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (hreadyout === 1'b1) break;
    end
    if (k == 50) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= wr;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask
  // Holds the switch well past the debounce time, then releases it as long
  task automatic press(input int a, input int b);
    switch_press <= 10'(1 << a) | ((b >= 0) ? 10'(1 << b) : 10'h000);
    repeat (DEB + 12) @(posedge clk);
    switch_press <= '0;
    repeat (DEB + 12) @(posedge clk);
  endtask
  task automatic wait_quiet(input logic run);
    int k;
    for (k = 0; k < 300; k++) begin
      @(posedge clk);
      if (mem_req === 1'b0 && tape_ready === 1'b0 && core_run === run) break;
    end
    if (k == 300) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  initial begin
    {rst_n, hsel, hwrite, slow, bank} = '0;
    {haddr, hwdata, htrans, step_mode, switch_press, sel} = '0;
    hsize = 3'h2;
    data_sw = '0;
    addr_sw = '0;
    {n_fail, n_tests, n_start, n_step, n_run_single_switch_instruction, n_clear} = '0;
    last_kind = '0;
    for (i = 0; i < 12; i++) left_src[i] = 18'(i * 7 + 1);
    for (i = 0; i < 12; i++) right_src[i] = 18'h3_ffff - 18'(i);
    for (i = 0; i < 32768; i++) u_model.mem[i] = '0;
    u_model.mem[15'h0030] = 18'h0_5a5a;
    u_model.mem[15'h0031] = 18'h0_a5a5;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, console_pkg::OFF_STATUS, '0, rdv);
    chk("status", '0, rdv);
    bus(0, 8'h20, '0, rdv);
    chk("unmapped", '0, rdv);
    chk("hresp", '0, 32'(hresp));
    bus(1, console_pkg::OFF_CTRL, 32'h0000_0001, rdv);
    addr_sw <= 15'h0010;
    data_sw <= 18'h2_abcd;
    press(console_pkg::SW_ST_THIS, -1);
    chk("locked store", '0, 32'(u_model.mem[15'h0010]));
    bus(1, console_pkg::OFF_CTRL, '0, rdv);
    press(console_pkg::SW_ST_THIS, -1);
    wait_quiet(0);
    chk("store this", 32'h0002_abcd, 32'(u_model.mem[15'h0010]));
    addr_sw <= 15'h0020;
    data_sw <= 18'h1_1111;
    press(console_pkg::SW_ST_NEXT, -1);
    data_sw <= 18'h1_2222;
    press(console_pkg::SW_ST_NEXT, -1);
    wait_quiet(0);
    chk("store next 0", 32'h0001_1111, 32'(u_model.mem[15'h0020]));
    chk("store next 1", 32'h0001_2222, 32'(u_model.mem[15'h0021]));
    slow <= 1'b1;
    addr_sw <= 15'h0010;
    press(console_pkg::SW_LD_THIS, -1);
    wait_quiet(0);
    chk("load this", 32'h0002_abcd, 32'(mbuf));
    addr_sw <= 15'h0030;
    for (i = 0; i < 2; i++) begin
      press(console_pkg::SW_LD_NEXT, -1);
      wait_quiet(0);
      chk("load next", 32'(u_model.mem[15'h0030 + 15'(i)]), 32'(mbuf));
    end
    bus(0, console_pkg::OFF_MBUF, '0, rdv);
    chk("buffer reg", 32'h0000_a5a5, rdv);
    chk("core pulses", '0, 32'(n_start + n_step + n_clear));
    press(console_pkg::SW_RESET, -1);
    chk("reset buffer", '0, 32'(mbuf));
    chk("reset pulses", 32'h0000_0001, 32'(n_clear));
    data_sw <= 18'h1_2345;
    press(console_pkg::SW_RUN_SINGLE_SWITCH_INSTRUCTION, -1);
    wait_quiet(0);
    chk("run_single_switch_instruction word", 32'h0001_2345, 32'(run_single_switch_instruction_word));
    chk("run_single_switch_instruction count", 32'h0000_0001, 32'(n_run_single_switch_instruction));
    for (m = 1; m < 4; m++) begin
      step_mode <= 2'(m);
      press(console_pkg::SW_RESUME, -1);
      wait_quiet(0);
      chk("step kind", 32'(m), 32'(last_kind));
      chk("step count", 32'(m), 32'(n_step));
    end
    step_mode <= console_pkg::STEP_NONE;
    addr_sw <= 15'h0100;
    press(console_pkg::SW_START, -1);
    chk("start addr", 32'h0000_0100, 32'(start_addr));
    chk("running", 32'h0000_0001, 32'(core_run));
    addr_sw <= 15'h0040;
    press(console_pkg::SW_ST_THIS, -1);
    chk("store while running", '0, 32'(u_model.mem[15'h0040]));
    press(console_pkg::SW_STOP, -1);
    wait_quiet(0);
    chk("stopped", '0, 32'(core_run));
    press(console_pkg::SW_RESUME, -1);
    chk("resumed", 32'h0000_0001, 32'(core_run));
    chk("no restart", 32'h0000_0001, 32'(n_start));
    press(console_pkg::SW_RESET, console_pkg::SW_STOP);
    wait_quiet(0);
    chk("forced reset", 32'h0000_0002, 32'(n_clear));
    addr_sw <= 15'h0200;
    press(console_pkg::SW_TAPE_BOOTSTRAP_LOAD, -1);
    wait_quiet(0);
    for (i = 0; i < 3; i++) chk("tape word", 32'h0003_0000 + 32'(i), 32'(u_model.mem[15'h0200 + 15'(i)]));
    for (m = 0; m < 2; m++) begin
      for (i = 0; i < 13; i++) begin
        bank <= 1'(m);
        sel <= 4'(i);
        repeat (3) @(posedge clk);
        chk("lamps", (i > 11) ? '0 : 32'(m ? right_src[i] : left_src[i]), 32'(lamps));
      end
    end
    report_and_stop();
  end
endmodule // operator_console_control_tb_top
`default_nettype wire
